// file: rtl/port_c_alt_mux.sv
// Notes on behaviour
// R1: Port bit n drives pin-change line 8+n.
// R2: Bit 7 carries DAC output and amplifier input.
// R3: DAC enable and analog disables force input off.
// R4: Software keeps amplifier pins input, pull-up off.
// R5: Software keeps comparator pins input, pull-up off.
// R6: Bit 3 feeds timer-one count, CAN receive, capture.
// R7: Bit 2 feeds timer-zero count, carries CAN transmit.
// R8: Match-B reaches pin only with direction set.
// R9: Bit 1 match-B override; stage input, select read.
// R10: SPI slave forces select pin to input.
// R11: Slave SPI active only while select low.
// R12: SPI master leaves select direction to software.
// R13: Forced select pin pull-up follows latch bit.
// R14: Stage output enable drives bit 0 as output.
// R15: Bit 0 is external interrupt three source.
// R16: Override enable replaces register setting per pin.
module port_c_alt_mux
(
  input  wire logic       i_clk_sys,               // System clock, 100 MHz.
  input  wire logic       i_srst,                  // Synchronous reset, active high.
  input  wire logic [7:0] i_port_latch,            // Software output latch bits.
  input  wire logic [7:0] i_port_dir,              // Software direction bits, 1 is output.
  input  wire logic       i_pullup_disable,        // Global pull-up disable.
  input  wire logic [7:0] i_pad_in,                // Raw pad levels from the board.
  input  wire logic       i_dac_enable_bit,        // DAC drives bit 7.
  input  wire logic       i_analog10_input_disable,// Digital input off on bit 6.
  input  wire logic       i_analog9_input_disable, // Digital input off on bit 5.
  input  wire logic       i_analog8_input_disable, // Digital input off on bit 4.
  input  wire logic       i_match_b_out_enable,    // Timer-one match B owns the bit 1 value.
  input  wire logic       i_timer_one_match_b_out, // Timer-one match B level.
  input  wire logic       i_can_transmit_pin,      // CAN transmit data.
  input  wire logic       i_can_tx_enable,         // CAN transmitter owns bit 2.
  input  wire logic       i_stage_out_enable_10,   // Power stage owns bit 0.
  input  wire logic       i_stage_out_value_10,    // Power stage output level.
  input  wire logic       i_ext_irq3_enable,       // External interrupt 3 enabled.
  input  wire logic       i_spi_enable,            // SPI enabled.
  input  wire logic       i_spi_master,            // SPI is master.
  input  wire logic       i_port_d0_latch,         // Latch bit of the select pin.
  input  wire logic       i_direction_bit_d0,      // Direction bit of the select pin.
  output logic [7:0]      o_pad_out,               // Pad output levels.
  output logic [7:0]      o_pad_oe,                // Pad output enables, high drives.
  output logic [7:0]      o_pad_pullup,            // Pad pull-up enables.
  output logic [7:0]      o_pad_input_en,          // Digital input enables.
  output logic [7:0]      o_pin_read_value,        // Read-back of the pins.
  output logic [15:8]     o_pin_change_line,       // Pin-change lines 8 to 15.
  output logic            o_timer_one_count_input, // Timer-one count source.
  output logic            o_timer_zero_count_input,// Timer-zero count source.
  output logic            o_can_receive_pin,       // CAN receive data.
  output logic            o_capture_alt_input,     // Timer-one alternate capture.
  output logic            o_power_stage_input_1,   // Power stage digital input 1.
  output logic            o_alt_slave_select,      // Alternate SPI slave select level.
  output logic            o_spi_slave_active,      // Slave SPI selected.
  output logic            o_ext_irq_3,             // External interrupt 3 level.
  output logic            o_dac_out_enable,        // DAC analog path on bit 7.
  output logic            o_select_pullup,         // Pull-up of the select pin.
  output logic            o_select_dir             // Direction of the select pin.
);
  logic [7:0] sync_pad;       // Synchronised pad levels.
  logic [7:0] pullup_override_enable;
  logic [7:0] pullup_override_value;
  logic [7:0] direction_override_enable;
  logic [7:0] direction_override_value;
  logic [7:0] pin_value_override_enable;
  logic [7:0] pin_value_override_value;
  logic [7:0] input_enable_override_enable;
  logic [7:0] input_enable_override_value;
  logic [7:0] pad_out_next;   // Resolved output levels.
  logic [7:0] pad_oe_next;    // Resolved directions.
  logic [7:0] pad_pu_next;    // Resolved pull-ups.
  logic [7:0] pad_ie_next;    // Resolved input enables.
  logic [7:0] pin_read_next;  // Gated read-back.
  logic       select_forced;  // SPI slave owns the select pin.

  // Pad levels come from the board, so they are synchronised first.
  port_c_pin_sync u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_pad_in),
    .o_sync    (sync_pad)
  );

  // Pick the override when enabled, else the register setting.
  function automatic logic pick(input logic ovr_en, input logic ovr_val, input logic reg_val);
    pick = ovr_en ? ovr_val : reg_val; // [R16]
  endfunction : pick

  // Override table of the port. No pin overrides its pull-up.
  always_comb
  begin
    pullup_override_enable       = 8'h00;
    pullup_override_value        = 8'h00;
    direction_override_enable    = 8'h00;
    direction_override_value     = 8'h00;
    pin_value_override_enable    = 8'h00;
    pin_value_override_value     = 8'h00;
    input_enable_override_enable = 8'h00;
    input_enable_override_value  = 8'h00;
    // The DAC owns bit 7: output driver and digital input are both off.
    direction_override_enable[port_c_mux_pkg::BIT_DAC]    = i_dac_enable_bit; // [R2] [R3]
    input_enable_override_enable[port_c_mux_pkg::BIT_DAC] = i_dac_enable_bit; // [R3]
    // Analog input disables only switch the digital input off.
    input_enable_override_enable[port_c_mux_pkg::BIT_AN10] = i_analog10_input_disable; // [R3]
    input_enable_override_enable[port_c_mux_pkg::BIT_AN9]  = i_analog9_input_disable;  // [R3]
    input_enable_override_enable[port_c_mux_pkg::BIT_AN8]  = i_analog8_input_disable;  // [R3]
    // Bits 3 and 2 are inputs for the timers; CAN transmit takes bit 2 as output.
    direction_override_value[port_c_mux_pkg::BIT_CAN_RX] = 1'h1;
    direction_override_value[port_c_mux_pkg::BIT_CAN_TX] = 1'h1;
    direction_override_enable[port_c_mux_pkg::BIT_CAN_TX] = i_can_tx_enable;  // [R7]
    pin_value_override_enable[port_c_mux_pkg::BIT_CAN_TX] = i_can_tx_enable;  // [R7]
    pin_value_override_value[port_c_mux_pkg::BIT_CAN_TX]  = i_can_transmit_pin; // [R7]
    // Match B overrides only the value; direction stays with software.
    pin_value_override_enable[port_c_mux_pkg::BIT_MATCH_B] = i_match_b_out_enable;    // [R9] [R8]
    pin_value_override_value[port_c_mux_pkg::BIT_MATCH_B]  = i_timer_one_match_b_out; // [R9]
    // Power stage makes bit 0 an output carrying its own level.
    direction_override_enable[port_c_mux_pkg::BIT_EXT_IRQ] = i_stage_out_enable_10; // [R14]
    direction_override_value[port_c_mux_pkg::BIT_EXT_IRQ]  = 1'h1;                  // [R14]
    pin_value_override_enable[port_c_mux_pkg::BIT_EXT_IRQ] = i_stage_out_enable_10; // [R14]
    pin_value_override_value[port_c_mux_pkg::BIT_EXT_IRQ]  = i_stage_out_value_10;  // [R14]
    // Interrupt 3 forces the digital input enable of bit 0 on.
    input_enable_override_enable[port_c_mux_pkg::BIT_EXT_IRQ] = i_ext_irq3_enable; // [R15]
    input_enable_override_value[port_c_mux_pkg::BIT_EXT_IRQ]  = i_ext_irq3_enable; // [R15]
  end

  // Resolve every pin the same way; pull-up needs input, latch high, not disabled.
  genvar gi;
  generate
    for (gi = 0; gi < port_c_mux_pkg::PORT_WIDTH; gi++)
    begin : g_pin
      always_comb
      begin
        pad_oe_next[gi]   = pick(direction_override_enable[gi], direction_override_value[gi],
                                 i_port_dir[gi]);                          // [R16]
        pad_out_next[gi]  = pick(pin_value_override_enable[gi], pin_value_override_value[gi],
                                 i_port_latch[gi]);                        // [R16]
        pad_pu_next[gi]   = pick(pullup_override_enable[gi], pullup_override_value[gi],
                                 i_port_latch[gi] & ~i_port_dir[gi] & ~i_pullup_disable);
        pad_ie_next[gi]   = pick(input_enable_override_enable[gi],
                                 input_enable_override_value[gi], 1'h1);   // [R16]
        pin_read_next[gi] = sync_pad[gi] & pad_ie_next[gi];
      end
    end
  endgenerate

  // Slave mode takes the select pin away from its direction bit.
  assign select_forced = i_spi_enable & ~i_spi_master; // [R10] [R12]

  // Pad drive registers; match B only leaves the chip while the direction bit is one.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_pad_out      <= port_c_mux_pkg::RST_BYTE;
      o_pad_oe       <= port_c_mux_pkg::RST_BYTE;
      o_pad_pullup   <= port_c_mux_pkg::RST_BYTE;
      o_pad_input_en <= port_c_mux_pkg::RST_BYTE;
    end
    else
    begin
      o_pad_out      <= pad_out_next;
      o_pad_oe       <= pad_oe_next; // [R8]
      o_pad_pullup   <= pad_pu_next;
      o_pad_input_en <= pad_ie_next;
    end
  end

  // Read-back and peripheral inputs, all from the gated pin value.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_pin_read_value         <= port_c_mux_pkg::RST_BYTE;
      o_pin_change_line        <= port_c_mux_pkg::RST_BYTE;
      o_timer_one_count_input  <= port_c_mux_pkg::RST_BIT;
      o_timer_zero_count_input <= port_c_mux_pkg::RST_BIT;
      o_can_receive_pin        <= port_c_mux_pkg::RST_BIT;
      o_capture_alt_input      <= port_c_mux_pkg::RST_BIT;
      o_power_stage_input_1    <= port_c_mux_pkg::RST_BIT;
      o_alt_slave_select       <= port_c_mux_pkg::RST_BIT;
      o_ext_irq_3              <= port_c_mux_pkg::RST_BIT;
    end
    else
    begin
      o_pin_read_value         <= pin_read_next;
      o_pin_change_line        <= pin_read_next; // [R1]
      o_timer_one_count_input  <= pin_read_next[port_c_mux_pkg::BIT_CAN_RX]; // [R6]
      o_can_receive_pin        <= pin_read_next[port_c_mux_pkg::BIT_CAN_RX]; // [R6]
      o_capture_alt_input      <= pin_read_next[port_c_mux_pkg::BIT_CAN_RX]; // [R6]
      o_timer_zero_count_input <= pin_read_next[port_c_mux_pkg::BIT_CAN_TX]; // [R7]
      o_power_stage_input_1    <= pin_read_next[port_c_mux_pkg::BIT_MATCH_B]; // [R9]
      o_alt_slave_select       <= pin_read_next[port_c_mux_pkg::BIT_MATCH_B]; // [R9]
      o_ext_irq_3              <= pin_read_next[port_c_mux_pkg::BIT_EXT_IRQ]; // [R15]
    end
  end

  // Slave-select control and DAC path. The select pin level is low-active.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_spi_slave_active <= port_c_mux_pkg::RST_BIT;
      o_dac_out_enable   <= port_c_mux_pkg::RST_BIT;
      o_select_pullup    <= port_c_mux_pkg::RST_BIT;
      o_select_dir       <= port_c_mux_pkg::RST_BIT;
    end
    else
    begin
      o_spi_slave_active <= select_forced & ~pin_read_next[port_c_mux_pkg::BIT_MATCH_B]; // [R11]
      o_dac_out_enable   <= i_dac_enable_bit; // [R2]
      // Even when forced to input, the pull-up still tracks the latch bit.
      o_select_pullup    <= (select_forced | ~i_direction_bit_d0) & i_port_d0_latch
                            & ~i_pullup_disable; // [R13]
      o_select_dir       <= select_forced ? 1'h0 : i_direction_bit_d0; // [R10] [R12]
    end
  end

  // Input enable on bit 7 stays low while the DAC is on.
  property p_dac_input_off;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_dac_enable_bit |=> !o_pad_input_en[7] && !o_pad_oe[7];
  endproperty
  a_dac_input_off: assert property (p_dac_input_off) // [R3]
    else $error("DAC pin not released");

  // A slave-mode select pin is never driven.
  property p_slave_input;
    @(posedge i_clk_sys) disable iff (i_srst)
      select_forced |=> !o_select_dir;
  endproperty
  a_slave_input: assert property (p_slave_input) // [R10]
    else $error("Select pin driven in slave mode");

  // Master mode follows software direction.
  property p_master_dir;
    @(posedge i_clk_sys) disable iff (i_srst)
      !select_forced |=> o_select_dir == $past(i_direction_bit_d0);
  endproperty
  a_master_dir: assert property (p_master_dir) // [R12]
    else $error("Select direction ignores software");

  // Slave active needs slave mode.
  property p_slave_active;
    @(posedge i_clk_sys) disable iff (i_srst)
      o_spi_slave_active |-> $past(select_forced);
  endproperty
  a_slave_active: assert property (p_slave_active) // [R11]
    else $error("Slave active outside slave mode");

  // Stage output makes bit 0 an output with its level.
  property p_stage_out;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_stage_out_enable_10 |=> o_pad_oe[0] && o_pad_out[0] == $past(i_stage_out_value_10);
  endproperty
  a_stage_out: assert property (p_stage_out) // [R14]
    else $error("Stage output not on bit 0");

  // Match B value on bit 1.
  property p_match_b;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_match_b_out_enable |=> o_pad_out[1] == $past(i_timer_one_match_b_out);
  endproperty
  a_match_b: assert property (p_match_b) // [R9]
    else $error("Match B value wrong");

  // Interrupt 3 keeps the input on.
  property p_irq3_input;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ext_irq3_enable |=> o_pad_input_en[0];
  endproperty
  a_irq3_input: assert property (p_irq3_input) // [R15]
    else $error("Interrupt 3 input gated");

  // Pin-change lines mirror read-back; the end lines must come from the end bits.
  // The first edge after reset is skipped, since the flops were cleared there.
  property p_pin_change;
    @(posedge i_clk_sys) disable iff (i_srst)
      !$past(i_srst) |-> o_pin_change_line == o_pin_read_value
        && o_pin_change_line[8] == $past(sync_pad[0] & pad_ie_next[0])
        && o_pin_change_line[15] == $past(sync_pad[7] & pad_ie_next[7]);
  endproperty
  a_pin_change: assert property (p_pin_change) // [R1]
    else $error("Pin-change line mismatch");
endmodule : port_c_alt_mux

// file: include/port_c_mux_pkg.sv
package port_c_mux_pkg;
  // Number of pins on the port.
  localparam int PORT_WIDTH = 8;
  // First pin-change interrupt line fed by this port.
  localparam int PCINT_BASE = 8;
  // Bit positions of the pins with special roles.
  localparam int BIT_EXT_IRQ    = 0;
  localparam int BIT_MATCH_B    = 1;
  localparam int BIT_CAN_TX     = 2;
  localparam int BIT_CAN_RX     = 3;
  localparam int BIT_AN8        = 4;
  localparam int BIT_AN9        = 5;
  localparam int BIT_AN10       = 6;
  localparam int BIT_DAC        = 7;
  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic       RST_BIT  = 1'h0;
  // Number of flip-flops in each input synchroniser.
  localparam int SYNC_STAGES = 2;
endpackage : port_c_mux_pkg

// file: rtl/port_c_pin_sync.sv
module port_c_pin_sync
(
  input  wire logic       i_clk_sys,  // System clock.
  input  wire logic       i_srst,     // Synchronous reset, active high.
  input  wire logic [7:0] i_async,    // Raw pad levels.
  output logic      [7:0] o_sync      // Synchronised pad levels.
);
  // First stage; read only by the second stage.
  logic [7:0] meta_reg;

  // Two-flop synchroniser, one bit per pad.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      meta_reg <= port_c_mux_pkg::RST_BYTE;
      o_sync   <= port_c_mux_pkg::RST_BYTE;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule : port_c_pin_sync

// file: test/port_c_board_model.sv
// Board side of port C: resolves each wire from the device drive, the board drive and
// the pull-up. A floating wire without a pull-up shows the inverse of the board value,
// so a stale level can never pass for a read.
module port_c_board_model
(
  input  wire logic [7:0] i_pad_out,     // Device pad levels.
  input  wire logic [7:0] i_pad_oe,      // Device drive enables.
  input  wire logic [7:0] i_pad_pullup,  // Device pull-up enables.
  input  wire logic [7:0] i_board_val,   // Level the board drives.
  input  wire logic       i_board_drive, // Board drives every undriven pin.
  output logic      [7:0] o_pad_level    // Resolved wire level.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_level; // Level of a wire that nobody drives.

  // Released wires go high through the pull-up, otherwise to a changed level.
  assign float_level = i_pad_pullup | ~i_board_val;
  // The device wins where it drives; the board only drives inputs.
  assign o_pad_level = (i_pad_oe & i_pad_out)
                     | (~i_pad_oe & (i_board_drive ? i_board_val : float_level));
endmodule : port_c_board_model

// file: test/tb_port_c_alt_mux.sv
module tb_port_c_alt_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;         // System clock.
  logic        srst;        // Synchronous reset.
  logic [7:0]  latch, dir;  // Software latch and direction bits.
  logic [7:0]  board;       // Level the board drives.
  logic [16:0] ctl;         // Control bits, bit 16 is board drive.
  logic [7:0]  pad_out, pad_oe, pad_pu, pad_ie, rd, pad; // Pad side.
  logic [15:8] pcl;         // Pin-change lines.
  logic        t1c, t0c, canr, cap, ps1, sel, act, irq3, dac, selpu, seldir; // Taps.
  int          err_count;   // Mismatches.
  int          n_tests;     // Comparisons.
  int          cycles = 0;  // Cycle counter for the hang guard.

  port_c_alt_mux dut_u (.i_clk_sys(clk), .i_srst(srst), .i_port_latch(latch),
    .i_port_dir(dir), .i_pullup_disable(ctl[0]), .i_pad_in(pad),
    .i_dac_enable_bit(ctl[1]), .i_analog10_input_disable(ctl[2]),
    .i_analog9_input_disable(ctl[3]), .i_analog8_input_disable(ctl[4]),
    .i_match_b_out_enable(ctl[5]), .i_timer_one_match_b_out(ctl[6]),
    .i_can_transmit_pin(ctl[7]), .i_can_tx_enable(ctl[8]),
    .i_stage_out_enable_10(ctl[9]), .i_stage_out_value_10(ctl[10]),
    .i_ext_irq3_enable(ctl[11]), .i_spi_enable(ctl[12]), .i_spi_master(ctl[13]),
    .i_port_d0_latch(ctl[14]), .i_direction_bit_d0(ctl[15]),
    .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_pullup(pad_pu),
    .o_pad_input_en(pad_ie), .o_pin_read_value(rd), .o_pin_change_line(pcl),
    .o_timer_one_count_input(t1c), .o_timer_zero_count_input(t0c),
    .o_can_receive_pin(canr), .o_capture_alt_input(cap),
    .o_power_stage_input_1(ps1), .o_alt_slave_select(sel),
    .o_spi_slave_active(act), .o_ext_irq_3(irq3), .o_dac_out_enable(dac),
    .o_select_pullup(selpu), .o_select_dir(seldir));

  port_c_board_model board_u (.i_pad_out(pad_out), .i_pad_oe(pad_oe),
    .i_pad_pullup(pad_pu), .i_board_val(board), .i_board_drive(ctl[16]),
    .o_pad_level(pad));

  // Compare one value and count it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Print the counts and the verdict, then stop.
  task automatic conclude;
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Apply one setting, let the four-edge pad path settle, then check every output.
  task automatic go(input logic [7:0] l, input logic [7:0] d, input logic [7:0] b,
                    input logic [16:0] c);
    logic [7:0] oe, po, pu, ie, ep, er;
    logic       sl;
    @(negedge clk);
    latch = l;
    dir   = d;
    board = b;
    ctl   = c;
    repeat (4) @(negedge clk);
    oe = d;
    po = l;
    ie = 8'hFF;
    pu = l & ~d & {8{~c[0]}};
    oe[7] = c[1] ? 1'b0 : d[7];
    oe[2] = c[8] ? 1'b1 : d[2];
    oe[0] = c[9] ? 1'b1 : d[0];
    po[2] = c[8] ? c[7] : l[2];
    po[1] = c[5] ? c[6] : l[1];
    po[0] = c[9] ? c[10] : l[0];
    ie[7:4] = ~{c[1], c[2], c[3], c[4]};
    ep = (oe & po) | (~oe & (c[16] ? b : (pu | ~b)));
    er = ep & ie;
    sl = c[12] & ~c[13];
    chk(pad_oe, oe);
    chk(pad_out, po);
    chk(pad_pu, pu);
    chk(pad_ie, ie);
    chk(rd, er);
    chk(pcl, er);
    chk({4'h0, t1c, canr, cap, t0c}, {4'h0, er[3], er[3], er[3], er[2]});
    chk({4'h0, ps1, sel, irq3, dac}, {4'h0, er[1], er[1], er[0], c[1]});
    chk({5'h00, act, seldir, selpu},
        {5'h00, sl & ~er[1], sl ? 1'b0 : c[15], (sl | ~c[15]) & c[14] & ~c[0]});
  endtask : go

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      err_count++;
      conclude();
    end
  end

  // Main sequence: reset, then one table row per setting, back to back.
  initial
  begin
    err_count = 0;
    n_tests = 0;
    srst = 1'b1;
    latch = 8'h00;
    dir = 8'h00;
    board = 8'h00;
    ctl = 17'h10000;
    repeat (10) @(negedge clk);
    chk(pad_oe | pad_out | rd, 8'h00);
    srst = 1'b0;
    go(8'hA5, 8'h0F, 8'h3C, 17'h10000);
    go(8'hA5, 8'h0F, 8'h3C, 17'h10001);
    go(8'hA5, 8'h0F, 8'h3C, 17'h00000);
    go(8'h00, 8'h80, 8'hFF, 17'h1001E);
    go(8'h00, 8'h02, 8'h00, 17'h10060);
    go(8'h00, 8'h00, 8'h00, 17'h10060);
    go(8'h00, 8'h00, 8'h00, 17'h10E00);
    go(8'h01, 8'h01, 8'h01, 17'h10A00);
    go(8'h04, 8'h04, 8'h04, 17'h10100);
    go(8'h00, 8'h00, 8'h00, 17'h1D000);
    go(8'h00, 8'h00, 8'h02, 17'h1D000);
    go(8'h00, 8'h00, 8'h00, 17'h1B000);
    go(8'h00, 8'h00, 8'h00, 17'h17000);
    conclude();
  end
endmodule : tb_port_c_alt_mux
